// [lsr_core.v]
// LIN slave read-back of settings frame two and the brief status query.
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "lsr_defs.vh"
// How it works
// - A brief status query with our address answers with the address byte and one status byte.
// - Answering the brief status query never clears a latched flag.
// - Latched flags clear only on the full-status execute strobe.
// - The LIN error bit is the OR of all detected LIN error conditions.
// - Each LED error bit is set when that channel's three-bit fault code is nonzero.
// - The retry bit follows the live automatic-recovery state.
// - Undervoltage is zero after reset, latches on undervoltage, clears only by full status.
// - Settings response two carries a21, a22, a23, a31, a32, a33 in data bytes two to seven.
// - Settings read-back is a diagnostic request followed by a separate slave response.
// - With the command-disable bit programmed, these commands are ignored.
module lsr_core (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_rst,
    // Received frame bytes from the LIN protocol layer
    input  wire        i_frame_start,
    input  wire        i_diag_frame,
    input  wire        i_rx_valid,
    input  wire [7:0]  i_rx_byte,
    input  wire        i_resp_req,
    input  wire        i_tx_ready,
    // Settings memory
    input  wire [5:0]  i_node_addr,
    input  wire        i_command_disable_bit,
    input  wire [47:0] i_coef_lower,
    input  wire        i_second_lock_bit,
    input  wire        i_modulation_rate_select,
    input  wire        i_thermal_regulation_enable,
    input  wire [3:0]  i_group_member_bits,
    // Device health pins, asynchronous
    input  wire        i_thermal_shutdown_flag,
    input  wire        i_thermal_warning_flag,
    input  wire        i_undervoltage,
    input  wire        i_retry_active,
    input  wire [2:0]  i_channel1_fault_code,
    input  wire [2:0]  i_channel2_fault_code,
    input  wire [2:0]  i_channel3_fault_code,
    input  wire [3:0]  i_lin_errors,
    // Full-status command executed elsewhere
    input  wire        i_full_status_exec,
    // Register port
    input  wire [3:0]  i_addr,
    input  wire [7:0]  i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [7:0]  o_rdata,
    // Response stream
    output reg         o_tx_valid,
    output reg  [7:0]  o_tx_byte,
    output reg         o_tx_last,
    // Interrupt
    output reg         o_irq
);
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_RECV = 4'h2;
    localparam [3:0] ST_WAIT = 4'h4;
    localparam [3:0] ST_SEND = 4'h8;
    localparam [1:0] K_NONE = 2'h0;
    localparam [1:0] K_STAT = 2'h1;
    localparam [1:0] K_SET2 = 2'h2;

    // Two-flop synchronisers for all asynchronous health inputs.
    // Seventeen raw bits: four single flags, three fault codes and four LIN error lines.
    wire [16:0] raw_in = {i_thermal_shutdown_flag, i_thermal_warning_flag, i_undervoltage, i_retry_active,
                          i_channel1_fault_code, i_channel2_fault_code, i_channel3_fault_code, i_lin_errors};
    reg  [16:0] sync1_reg;
    reg  [16:0] sync2_reg;
    always @(posedge i_clk) begin
        if (i_rst) begin
            sync1_reg <= 17'h0;
            sync2_reg <= 17'h0;
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end
    wire       s_tsd   = sync2_reg[16];
    wire       s_tw    = sync2_reg[15];
    wire       s_uv    = sync2_reg[14];
    wire       s_retry = sync2_reg[13];
    wire [2:0] s_ch1   = sync2_reg[12:10];
    wire [2:0] s_ch2   = sync2_reg[9:7];
    wire [2:0] s_ch3   = sync2_reg[6:4];
    wire [3:0] s_lin   = sync2_reg[3:0];

    // Latched error flags; retry is live and bypasses the latch.
    wire [7:0] fault_set;
    assign fault_set[`LSR_BIT_TSD]   = s_tsd;
    assign fault_set[`LSR_BIT_TW]    = s_tw;
    assign fault_set[`LSR_BIT_UV]    = s_uv;
    assign fault_set[`LSR_BIT_RETRY] = 1'b0;
    assign fault_set[`LSR_BIT_LED3]  = |s_ch3;
    assign fault_set[`LSR_BIT_LED2]  = |s_ch2;
    assign fault_set[`LSR_BIT_LED1]  = |s_ch1;
    assign fault_set[`LSR_BIT_LIN]   = |s_lin;
    wire [7:0] latched;
    lsr_fault_latch u_latch (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_set   (fault_set),
        .i_clear (i_full_status_exec),
        .o_flags (latched)
    );
    wire [7:0] status_byte = {latched[7:5], s_retry, latched[3:0]};

    // Request decoder and response sequencer.
    reg [3:0]  state_reg;
    reg [3:0]  idx_reg;
    reg        ok_reg;
    reg        is_diag_reg;
    reg [1:0]  pending_reg;
    reg        ev_stat;
    reg        ev_set;
    reg        ev_rej;
    reg [7:0]  resp_byte;
    reg [3:0]  resp_len;

    always @* begin
        resp_len = (pending_reg == K_STAT) ? `LSR_RESP_LEN_STAT : `LSR_RESP_LEN_DIAG;
        case (idx_reg)
            4'h0:    resp_byte = {`LSR_ADDR_PREFIX, i_node_addr};
            4'h1:    resp_byte = (pending_reg == K_STAT) ? status_byte : i_coef_lower[47:40];
            4'h2:    resp_byte = i_coef_lower[39:32];
            4'h3:    resp_byte = i_coef_lower[31:24];
            4'h4:    resp_byte = i_coef_lower[23:16];
            4'h5:    resp_byte = i_coef_lower[15:8];
            4'h6:    resp_byte = i_coef_lower[7:0];
            4'h7:    resp_byte = {i_second_lock_bit, i_modulation_rate_select, 1'b1,
                                  i_thermal_regulation_enable, i_group_member_bits};
            default: resp_byte = `LSR_FILLER;
        endcase
    end

    wire addr_byte_ok = (i_rx_byte == {`LSR_ADDR_PREFIX, i_node_addr});
    always @(posedge i_clk) begin
        if (i_rst) begin
            state_reg   <= ST_IDLE;
            idx_reg     <= 4'h0;
            ok_reg      <= 1'b0;
            is_diag_reg <= 1'b0;
            pending_reg <= K_NONE;
            o_tx_valid  <= 1'b0;
            o_tx_byte   <= 8'h00;
            o_tx_last   <= 1'b0;
            ev_stat     <= 1'b0;
            ev_set      <= 1'b0;
            ev_rej      <= 1'b0;
        end else begin
            ev_stat <= 1'b0;
            ev_set  <= 1'b0;
            ev_rej  <= 1'b0;
            if (i_frame_start) begin
                state_reg   <= ST_RECV;
                idx_reg     <= 4'h0;
                ok_reg      <= 1'b1;
                is_diag_reg <= i_diag_frame;
                o_tx_valid  <= 1'b0;
                o_tx_last   <= 1'b0;
                // A new diagnostic request drops any response left pending.
                if (i_diag_frame)
                    pending_reg <= K_NONE;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        o_tx_valid <= 1'b0;
                    end
                    ST_RECV: begin
                        if (i_rx_valid) begin
                            idx_reg <= idx_reg + 4'h1;
                            if (is_diag_reg) begin
                                case (idx_reg)
                                    4'h0: if (i_rx_byte != `LSR_APP_CMD) ok_reg <= 1'b0;
                                    4'h1: if (i_rx_byte != {1'b1, `LSR_SUB_SET2}) ok_reg <= 1'b0;
                                    4'h2: if (!addr_byte_ok) ok_reg <= 1'b0;
                                    default: if (i_rx_byte != `LSR_FILLER) ok_reg <= 1'b0;
                                endcase
                                if (idx_reg == `LSR_REQ_LEN_DIAG - 4'h1) begin
                                    state_reg <= ST_IDLE;
                                    if (ok_reg && i_rx_byte == `LSR_FILLER) begin
                                        if (i_command_disable_bit)
                                            ev_rej <= 1'b1;
                                        else
                                            pending_reg <= K_SET2;
                                    end
                                end
                            end else begin
                                if (idx_reg == 4'h0 && !addr_byte_ok)
                                    ok_reg <= 1'b0;
                                if (idx_reg == `LSR_REQ_LEN_STAT - 4'h1) begin
                                    if (ok_reg && i_rx_byte == `LSR_FILLER) begin
                                        if (i_command_disable_bit) begin
                                            ev_rej    <= 1'b1;
                                            state_reg <= ST_IDLE;
                                        end else begin
                                            pending_reg <= K_STAT;
                                            idx_reg     <= 4'h0;
                                            state_reg   <= ST_SEND;
                                        end
                                    end else begin
                                        state_reg <= ST_IDLE;
                                    end
                                end
                            end
                        end else if (i_resp_req && is_diag_reg == 1'b0 && pending_reg == K_SET2) begin
                            idx_reg   <= 4'h0;
                            state_reg <= ST_SEND;
                        end
                    end
                    ST_SEND: begin
                        if (!o_tx_valid || i_tx_ready) begin
                            if (idx_reg < resp_len) begin
                                o_tx_valid <= 1'b1;
                                o_tx_byte  <= resp_byte;
                                o_tx_last  <= (idx_reg == resp_len - 4'h1);
                                idx_reg    <= idx_reg + 4'h1;
                            end else begin
                                o_tx_valid  <= 1'b0;
                                o_tx_last   <= 1'b0;
                                state_reg   <= ST_IDLE;
                                ev_stat     <= (pending_reg == K_STAT);
                                ev_set      <= (pending_reg == K_SET2);
                                pending_reg <= K_NONE;
                            end
                        end
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end

    // Interrupt block; the status register is sticky and set wins over clear.
    reg [3:0] irq_stat_reg;
    reg [3:0] irq_en_reg;
    reg [7:0] ctrl_reg;
    reg       uv_prev_reg;
    wire [3:0] ev_vec = {ev_rej, latched[`LSR_BIT_UV] & ~uv_prev_reg, ev_set, ev_stat};
    wire [3:0] clr_vec = (i_wr && i_addr == `LSR_OFF_IRQ_CLR) ? i_wdata[3:0] : 4'h0;
    always @(posedge i_clk) begin
        if (i_rst) begin
            irq_stat_reg <= 4'h0;
            irq_en_reg   <= 4'h0;
            ctrl_reg     <= 8'h00;
            uv_prev_reg  <= 1'b0;
            o_irq        <= 1'b0;
            o_rdata      <= 8'h00;
        end else begin
            uv_prev_reg  <= latched[`LSR_BIT_UV];
            irq_stat_reg <= (irq_stat_reg & ~clr_vec) | ev_vec;
            if (i_wr && i_addr == `LSR_OFF_IRQ_EN)
                irq_en_reg <= i_wdata[3:0];
            if (i_wr && i_addr == `LSR_OFF_CTRL)
                ctrl_reg <= i_wdata;
            o_irq <= |(((irq_stat_reg & ~clr_vec) | ev_vec) & irq_en_reg);
            if (i_rd) begin
                case (i_addr)
                    `LSR_OFF_IRQ_STAT: o_rdata <= {4'h0, irq_stat_reg};
                    `LSR_OFF_IRQ_EN:   o_rdata <= {4'h0, irq_en_reg};
                    `LSR_OFF_FLAGS:    o_rdata <= status_byte;
                    `LSR_OFF_CTRL:     o_rdata <= ctrl_reg;
                    default:           o_rdata <= 8'h00;
                endcase
            end else begin
                o_rdata <= 8'h00;
            end
        end
    end
endmodule

// [lsr_defs.vh]
// Constants for the LIN status and settings read-back block.
`ifndef LSR_DEFS_VH
`define LSR_DEFS_VH
`define LSR_APP_CMD        8'h80
`define LSR_SUB_SET1       7'h04
`define LSR_SUB_SET2       7'h05
`define LSR_FILLER         8'hff
`define LSR_ADDR_PREFIX    2'h3
`define LSR_RESP_LEN_STAT  4'h2
`define LSR_RESP_LEN_DIAG  4'h8
`define LSR_REQ_LEN_DIAG   4'h8
`define LSR_REQ_LEN_STAT   4'h2
`define LSR_BIT_TSD        7
`define LSR_BIT_TW         6
`define LSR_BIT_UV         5
`define LSR_BIT_RETRY      4
`define LSR_BIT_LED3       3
`define LSR_BIT_LED2       2
`define LSR_BIT_LED1       1
`define LSR_BIT_LIN        0
`define LSR_LIN_ERR_W      4
`define LSR_EV_STATUS      0
`define LSR_EV_SETTINGS    1
`define LSR_EV_UV          2
`define LSR_EV_REJECT      3
`define LSR_EV_W           4
`define LSR_OFF_IRQ_STAT   4'h0
`define LSR_OFF_IRQ_CLR    4'h1
`define LSR_OFF_IRQ_EN     4'h2
`define LSR_OFF_FLAGS      4'h3
`define LSR_OFF_CTRL       4'h4
`endif

// [lsr_fault_latch.v]
// Latched fault flags with set-over-clear behaviour.
`timescale 1ns/100ps
module lsr_fault_latch (
    // Clock and reset
    input  wire       i_clk,
    input  wire       i_rst,
    // Raw fault levels, already synchronised
    input  wire [7:0] i_set,
    // Full-status clear strobe
    input  wire       i_clear,
    // Latched flags
    output wire [7:0] o_flags
);
    reg [7:0] flags_reg;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_bit
            // A fault present in the clearing cycle stays latched.
            always @(posedge i_clk) begin
                if (i_rst)
                    flags_reg[g] <= 1'b0;
                else if (i_set[g])
                    flags_reg[g] <= 1'b1;
                else if (i_clear)
                    flags_reg[g] <= 1'b0;
            end
        end
    endgenerate
    assign o_flags = flags_reg;
endmodule

// [lsr_core_monitor.sv]
// Checker for the response stream and register port of the read-back block.
`timescale 1ns/100ps
module lsr_core_monitor (
    // Clock, reset and register port
    input wire        i_clk,
    input wire        i_rst,
    input wire        i_rd,
    input wire [3:0]  i_addr,
    input wire [7:0]  o_rdata,
    // Response stream
    input wire        i_tx_ready,
    input wire        o_tx_valid,
    input wire [7:0]  o_tx_byte,
    input wire        o_tx_last,
    // Settings levels
    input wire [5:0]  i_node_addr,
    input wire        i_command_disable_bit,
    input wire [47:0] i_coef_lower,
    input wire        i_second_lock_bit,
    input wire        i_modulation_rate_select,
    input wire        i_thermal_regulation_enable,
    input wire [3:0]  i_group_member_bits
);
    reg  [2:0]  cnt_reg;
    wire [47:0] coef_sh = i_coef_lower << (8 * (cnt_reg - 3'd1));
    // Byte index on the stream; a dropped valid ends the response.
    always @(posedge i_clk) begin
        if (i_rst || !o_tx_valid) begin
            cnt_reg <= 3'd0;
        end else if (i_tx_ready) begin
            cnt_reg <= cnt_reg + 3'd1;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    a_rdata_unmapped: assert property ($past(i_rd) && $past(i_addr) > 4'h4 |-> o_rdata == 8'h00)
        else $error("unmapped read returned nonzero");
    a_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte) && $stable(o_tx_last))
        else $error("response byte changed before it was taken");
    a_first_byte: assert property ($rose(o_tx_valid) |-> o_tx_byte == {2'b11, i_node_addr})
        else $error("response does not open with the address byte");
    a_frame_len: assert property (o_tx_valid && o_tx_last |-> cnt_reg == 3'd1 || cnt_reg == 3'd7)
        else $error("response length is neither two nor eight bytes");
    a_coef_order: assert property (o_tx_valid && cnt_reg >= 3'd2 && cnt_reg <= 3'd6 |-> o_tx_byte == coef_sh[47:40])
        else $error("coefficient byte out of order");
    a_settings_tail: assert property (o_tx_valid && cnt_reg == 3'd7 |-> o_tx_last && o_tx_byte ==
        {i_second_lock_bit, i_modulation_rate_select, 1'b1, i_thermal_regulation_enable, i_group_member_bits})
        else $error("last settings byte wrong");
    a_disable_quiet: assert property ($rose(o_tx_valid) |-> !(i_command_disable_bit && $past(i_command_disable_bit, 8)))
        else $error("response sent while commands are disabled");
endmodule

// [lsr_lin_master.sv]
// LIN master model: sends request frames and takes in the slave response.
`timescale 1ns/100ps
module lsr_lin_master (
    // Clock and pacing
    input  wire       i_clk,
    input  wire       i_slow,
    // Response from the slave
    input  wire       i_tx_valid,
    input  wire [7:0] i_tx_byte,
    input  wire       i_tx_last,
    // Frames to the slave
    output reg        o_frame_start = 1'b0,
    output reg        o_diag_frame  = 1'b0,
    output reg        o_rx_valid    = 1'b0,
    output reg  [7:0] o_rx_byte     = 8'h00,
    output reg        o_resp_req    = 1'b0,
    output reg        o_tx_ready    = 1'b0
);
    reg     [7:0] resp [0:7];
    integer       n_resp = 0;
    reg           got = 1'b0;
    // A slow master is ready only every other cycle, so the slave must hold its output.
    always @(posedge i_clk) begin
        o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
        if (i_tx_valid && o_tx_ready) begin
            resp[n_resp[2:0]] <= i_tx_byte;
            n_resp <= n_resp + 1;
            got <= i_tx_last;
        end
    end
    // Idle data shows the inverse of the last byte rather than a stale copy.
    task send_frame(input dg, input rq, input integer n, input [63:0] b);
        integer i;
        begin
            @(posedge i_clk);
            o_frame_start <= 1'b1;
            o_diag_frame <= dg;
            got <= 1'b0;
            n_resp <= 0;
            @(posedge i_clk);
            o_frame_start <= 1'b0;
            o_resp_req <= rq;
            if (n == 0) @(posedge i_clk);
            for (i = 0; i < n; i = i + 1) begin
                o_rx_valid <= 1'b1;
                o_rx_byte <= b[63 - 8 * i -: 8];
                @(posedge i_clk);
                o_resp_req <= 1'b0;
            end
            o_rx_valid <= 1'b0;
            o_rx_byte <= ~o_rx_byte;
            o_resp_req <= 1'b0;
        end
    endtask
endmodule

// [tb_lin_status_otp_readback.sv]
// Self-checking bench for the LIN status and settings read-back block.
`timescale 1ns/100ps
module tb_lin_status_otp_readback;
    reg         i_clk = 1'b0;
    reg         i_rst = 1'b1;
    reg         slow = 1'b0, uv = 1'b0, fx = 1'b0, dis = 1'b0, wr = 1'b0, rd = 1'b0;
    reg  [15:0] hl = 16'h0000;
    reg  [5:0]  na = 6'h2a;
    reg  [3:0]  ra = 4'h0;
    reg  [7:0]  wd = 8'h00, d;
    reg  [63:0] es;
    wire        fs, dg, rv, rq, rdy, txv, txl, irq;
    wire [7:0]  rb, txb, rdata;
    integer     n_mismatch = 0, num_checks = 0, r, k;
    reg  [23:0] rows [0:9] = '{24'h000000, 24'h800080, 24'h400040, 24'h200010, 24'h004002,
                               24'h008004, 24'h080008, 24'h000801, 24'h000101, 24'h1c760b};
    always #25 i_clk = ~i_clk;
    lsr_lin_master i_master (.i_clk(i_clk), .i_slow(slow), .i_tx_valid(txv), .i_tx_byte(txb), .i_tx_last(txl),
        .o_frame_start(fs), .o_diag_frame(dg), .o_rx_valid(rv), .o_rx_byte(rb), .o_resp_req(rq), .o_tx_ready(rdy));
    lsr_core i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_frame_start(fs), .i_diag_frame(dg), .i_rx_valid(rv),
        .i_rx_byte(rb), .i_resp_req(rq), .i_tx_ready(rdy), .i_node_addr(na), .i_command_disable_bit(dis),
        .i_coef_lower(48'h1122334455aa), .i_second_lock_bit(1'b1), .i_modulation_rate_select(1'b0),
        .i_thermal_regulation_enable(1'b1), .i_group_member_bits(4'h9), .i_thermal_shutdown_flag(hl[15]),
        .i_thermal_warning_flag(hl[14]), .i_undervoltage(uv), .i_retry_active(hl[13]),
        .i_channel1_fault_code(hl[6:4]), .i_channel2_fault_code(hl[9:7]), .i_channel3_fault_code(hl[12:10]),
        .i_lin_errors(hl[3:0]), .i_full_status_exec(fx), .i_addr(ra), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .o_tx_valid(txv), .o_tx_byte(txb), .o_tx_last(txl), .o_irq(irq));
    task chk(input [8*10-1:0] nm, input [7:0] e, input [7:0] s);
        begin
            num_checks = num_checks + 1;
            if (s !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("MISMATCH %0s expected %h seen %h", nm, e, s);
            end
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", num_checks, n_mismatch);
            if (n_mismatch == 0 && num_checks > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask
    task reg_io(input w, input [3:0] a, input [7:0] v);
        begin
            @(posedge i_clk);
            wr <= w;
            rd <= ~w;
            ra <= a;
            wd <= v;
            @(posedge i_clk);
            wr <= 1'b0;
            rd <= 1'b0;
            #1 d = rdata;
        end
    endtask
    task frame(input f_dg, input f_rq, input integer n, input [63:0] b, input integer want);
        begin
            i_master.send_frame(f_dg, f_rq, n, b);
            for (k = 0; k < 60 && i_master.got !== 1'b1; k = k + 1) @(posedge i_clk);
            if (want > 0 && k == 60) begin
                n_mismatch = n_mismatch + 1;
                test_done;
            end
            #1 chk("resp_count", want, i_master.n_resp[7:0]);
        end
    endtask
    task query(input [7:0] b0, input [7:0] f, input [7:0] e, input integer want);
        begin
            frame(1'b0, 1'b0, 2, {b0, f, 48'h0}, want);
            if (want > 0) begin
                chk("addr_byte", {2'b11, na}, i_master.resp[0]);
                chk("stat_byte", e, i_master.resp[1]);
            end
        end
    endtask
    // Raw inputs must be low through the synchronisers first, or set wins over the clear.
    task clear_flags;
        begin
            hl <= 16'h0000;
            repeat (6) @(posedge i_clk);
            fx <= 1'b1;
            @(posedge i_clk);
            fx <= 1'b0;
            repeat (4) @(posedge i_clk);
        end
    endtask
    initial begin
        es = {2'b11, na, 48'h1122334455aa, 8'hb9};
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        #1 chk("tx_valid", 8'h00, {7'h0, txv});
        chk("irq", 8'h00, {7'h0, irq});
        reg_io(1'b1, 4'h2, 8'h0f);
        for (r = 0; r < 10; r = r + 1) begin
            hl <= rows[r][23:8];
            repeat (6) @(posedge i_clk);
            query({2'b11, na}, 8'hff, rows[r][7:0], 2);
            query({2'b11, na}, 8'hff, rows[r][7:0], 2);
            reg_io(1'b0, 4'h3, 8'h00);
            chk("flags_reg", rows[r][7:0], d);
            clear_flags;
        end
        $display("status table done");
        uv <= 1'b1;
        hl <= 16'h2000;
        repeat (6) @(posedge i_clk);
        uv <= 1'b0;
        hl <= 16'h0000;
        repeat (6) @(posedge i_clk);
        query({2'b11, na}, 8'hff, 8'h20, 2);
        query({2'b11, na}, 8'hff, 8'h20, 2);
        clear_flags;
        query({2'b11, na}, 8'hff, 8'h00, 2);
        $display("undervoltage latch done");
        chk("irq", 8'h01, {7'h0, irq});
        reg_io(1'b0, 4'h0, 8'h00);
        chk("irq_stat", 8'h05, d);
        reg_io(1'b1, 4'h1, 8'h0f);
        repeat (2) @(posedge i_clk);
        chk("irq", 8'h00, {7'h0, irq});
        reg_io(1'b1, 4'h2, 8'h00);
        query({2'b11, na}, 8'hff, 8'h00, 2);
        chk("irq", 8'h00, {7'h0, irq});
        reg_io(1'b0, 4'h0, 8'h00);
        chk("irq_stat", 8'h01, d);
        reg_io(1'b1, 4'h1, 8'h0f);
        $display("interrupt done");
        slow <= 1'b1;
        frame(1'b1, 1'b0, 8, {8'h80, 8'h85, 2'b11, na, 40'hffffffffff}, 0);
        frame(1'b0, 1'b1, 0, 64'h0, 8);
        for (r = 0; r < 8; r = r + 1) chk("set_byte", es[63 - 8 * r -: 8], i_master.resp[r]);
        slow <= 1'b0;
        $display("settings read done");
        query(8'hd5, 8'hff, 8'h00, 0);
        query({2'b11, na}, 8'hfe, 8'h00, 0);
        query({2'b01, na}, 8'hff, 8'h00, 0);
        dis <= 1'b1;
        query({2'b11, na}, 8'hff, 8'h00, 0);
        frame(1'b1, 1'b0, 8, {8'h80, 8'h85, 2'b11, na, 40'hffffffffff}, 0);
        frame(1'b0, 1'b1, 0, 64'h0, 0);
        reg_io(1'b0, 4'h0, 8'h00);
        chk("irq_stat", 8'h0a, d);
        dis <= 1'b0;
        $display("refusals done");
        reg_io(1'b1, 4'h9, 8'hff);
        reg_io(1'b0, 4'h9, 8'h00);
        chk("unmapped", 8'h00, d);
        reg_io(1'b1, 4'h4, 8'ha5);
        reg_io(1'b0, 4'h4, 8'h00);
        chk("scratch", 8'ha5, d);
        $display("register map done");
        test_done;
    end
endmodule
bind lsr_core lsr_core_monitor i_mon (.i_clk(i_clk), .i_rst(i_rst), .i_rd(i_rd), .i_addr(i_addr),
    .o_rdata(o_rdata), .i_tx_ready(i_tx_ready), .o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte),
    .o_tx_last(o_tx_last), .i_node_addr(i_node_addr), .i_command_disable_bit(i_command_disable_bit),
    .i_coef_lower(i_coef_lower), .i_second_lock_bit(i_second_lock_bit),
    .i_modulation_rate_select(i_modulation_rate_select),
    .i_thermal_regulation_enable(i_thermal_regulation_enable), .i_group_member_bits(i_group_member_bits));
